// File: inc/adcst_pkg.sv
// Package for the converter trim and input select control block.
// Assumes one 125 MHz clock mclk and a synchronous active-high reset.
package adcst_pkg;
   localparam int unsigned MCLK_MHZ        = 125;
   // Least low and high times of the trim request, in ns (plain defaults)
   localparam int unsigned TRIG_LOW_NS     = 80;
   localparam int unsigned TRIG_HIGH_NS    = 80;
   localparam int unsigned TRIG_LOW_CYC    = (TRIG_LOW_NS * MCLK_MHZ + 999) / 1000;
   localparam int unsigned TRIG_HIGH_CYC   = (TRIG_HIGH_NS * MCLK_MHZ + 999) / 1000;
   localparam int unsigned TRIM_CYC        = 64;
   localparam int unsigned CNT_W           = 8;

   localparam logic [3:0] REG_CFG          = 4'h0;
   localparam logic [3:0] REG_I_OFFSET     = 4'h2;
   localparam logic [3:0] REG_I_RANGE      = 4'h3;
   localparam logic [3:0] REG_Q_OFFSET     = 4'hA;
   localparam logic [3:0] REG_Q_RANGE      = 4'hB;

   localparam int unsigned CFG_TRIM_BIT    = 15;
   localparam int unsigned CFG_INTLV_BIT   = 7;
   localparam int unsigned CFG_ALT_BIT     = 6;

   localparam logic [15:0] CFG_RST         = 16'h0000;
   localparam logic [15:0] OFFSET_RST      = 16'h0000;
   localparam logic [15:0] RANGE_RST       = 16'h8000;
   // Pin-mode span values: low pin gives minimum, high pin gives mid
   localparam logic [15:0] RANGE_PIN_LO    = 16'h0000;
   localparam logic [15:0] RANGE_PIN_HI    = 16'h8000;

   typedef enum logic [2:0] {
      ADCST_IDLE = 3'b001,
      ADCST_ARM  = 3'b010,
      ADCST_RUN  = 3'b100
   } adcst_state_t;
endpackage

// File: rtl/adcst_sync.sv
// Two-flop synchroniser for one level from outside the mclk domain.
// Assumes the input is a slow level; first flop feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module adcst_sync (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic rst_val,
   input  wire logic d,
   output logic      q
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;

   always_comb begin
      nxt_meta = rst ? rst_val : d;
      nxt_sync = rst ? rst_val : meta_ff;
   end

   always_ff @(posedge mclk) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
   end

   assign q = sync_ff;
endmodule
`default_nettype wire

// File: rtl/adcst_top.sv
// Self-trim request handling, input routing and span/offset selection.
// Assumes pins are asynchronous to mclk; register writes come on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adcst_top
   import adcst_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        trim_req_pin,
   input  wire logic        ext_ctrl_enable_n,
   input  wire logic        interleave_pin,
   input  wire logic        input_span_select,
   input  wire logic        coupling_select,
   input  wire logic        reg_wr,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   output logic             trim_in_progress,
   output logic             extended_pin_override_mode,
   output logic             interleave_en,
   output logic             ch_i_uses_secondary,
   output logic             ch_q_uses_secondary,
   output logic             ch_q_active,
   output logic [15:0]      i_span,
   output logic [15:0]      q_span,
   output logic [15:0]      i_offset,
   output logic [15:0]      q_offset,
   output logic             input_bias_en
);
   logic              req_pin_s;
   logic              ext_en_n_s;
   logic              intlv_s;
   logic              span_s;
   logic              coup_s;
   logic              ext_mode;
   logic [15:0]       cfg_ff;
   logic [15:0]       i_off_ff;
   logic [15:0]       i_rng_ff;
   logic [15:0]       q_off_ff;
   logic [15:0]       q_rng_ff;
   logic [15:0]       nxt_cfg;
   logic [15:0]       nxt_i_off;
   logic [15:0]       nxt_i_rng;
   logic [15:0]       nxt_q_off;
   logic [15:0]       nxt_q_rng;
   logic              eff_req;
   adcst_state_t      state_ff;
   adcst_state_t      nxt_state;
   logic [CNT_W-1:0]  cnt_ff;
   logic [CNT_W-1:0]  nxt_cnt;
   logic              intlv_ff;
   logic              alt_ff;
   logic              ext_mode_ff;
   logic [15:0]       i_span_ff;
   logic [15:0]       q_span_ff;
   logic [15:0]       i_offo_ff;
   logic [15:0]       q_offo_ff;
   logic              bias_ff;
   logic              nxt_intlv;
   logic              nxt_alt;
   logic [15:0]       nxt_i_span;
   logic [15:0]       nxt_q_span;
   logic [15:0]       nxt_i_offo;
   logic [15:0]       nxt_q_offo;
   logic              nxt_ext_mode;
   logic              nxt_bias;

   adcst_sync u_sync_req (.mclk(mclk), .rst(rst), .rst_val(1'b1), .d(trim_req_pin), .q(req_pin_s));
   adcst_sync u_sync_ext (.mclk(mclk), .rst(rst), .rst_val(1'b1), .d(ext_ctrl_enable_n), .q(ext_en_n_s));
   adcst_sync u_sync_itl (.mclk(mclk), .rst(rst), .rst_val(1'b0), .d(interleave_pin), .q(intlv_s));
   adcst_sync u_sync_spn (.mclk(mclk), .rst(rst), .rst_val(1'b0), .d(input_span_select), .q(span_s));
   adcst_sync u_sync_cpl (.mclk(mclk), .rst(rst), .rst_val(1'b0), .d(coupling_select), .q(coup_s));

   assign ext_mode = ~ext_en_n_s;

   // Registers hold defaults whenever extended control is off
   always_comb begin
      nxt_cfg   = cfg_ff;
      nxt_i_off = i_off_ff;
      nxt_i_rng = i_rng_ff;
      nxt_q_off = q_off_ff;
      nxt_q_rng = q_rng_ff;
      if (rst || !ext_mode) begin
         nxt_cfg   = CFG_RST;
         nxt_i_off = OFFSET_RST;
         nxt_i_rng = RANGE_RST;
         nxt_q_off = OFFSET_RST;
         nxt_q_rng = RANGE_RST;
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_CFG:      nxt_cfg   = reg_wdata;
            REG_I_OFFSET: nxt_i_off = reg_wdata;
            REG_I_RANGE:  nxt_i_rng = reg_wdata;
            REG_Q_OFFSET: nxt_q_off = reg_wdata;
            REG_Q_RANGE:  nxt_q_rng = reg_wdata;
            default:      nxt_cfg   = cfg_ff;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      cfg_ff   <= nxt_cfg;
      i_off_ff <= nxt_i_off;
      i_rng_ff <= nxt_i_rng;
      q_off_ff <= nxt_q_off;
      q_rng_ff <= nxt_q_rng;
   end

   always_comb begin
      unique case (reg_addr)
         REG_CFG:      reg_rdata = {cfg_ff[15:1], trim_in_progress};
         REG_I_OFFSET: reg_rdata = i_off_ff;
         REG_I_RANGE:  reg_rdata = i_rng_ff;
         REG_Q_OFFSET: reg_rdata = q_off_ff;
         REG_Q_RANGE:  reg_rdata = q_rng_ff;
         default:      reg_rdata = 16'h0000;
      endcase
   end

   // Pin alone outside extended control, OR with the bit inside it
   assign eff_req = req_pin_s | (ext_mode & cfg_ff[CFG_TRIM_BIT]);

   // Low must last TRIG_LOW_CYC + 1 cycles, then high TRIG_HIGH_CYC, before trim starts
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      if (rst) begin
         nxt_state = ADCST_IDLE;
         nxt_cnt   = '0;
      end else begin
         unique case (state_ff)
            ADCST_IDLE: begin
               if (eff_req) begin
                  nxt_cnt = '0;
               end else if (cnt_ff < CNT_W'(TRIG_LOW_CYC)) begin
                  nxt_cnt = cnt_ff + 1'b1;
               end else begin
                  nxt_state = ADCST_ARM;
                  nxt_cnt   = '0;
               end
            end
            ADCST_ARM: begin
               if (!eff_req) begin
                  nxt_cnt = '0;
               end else if (cnt_ff < CNT_W'(TRIG_HIGH_CYC - 1)) begin
                  nxt_cnt = cnt_ff + 1'b1;
               end else begin
                  nxt_state = ADCST_RUN;
                  nxt_cnt   = '0;
               end
            end
            ADCST_RUN: begin
               // Requests are not looked at while the trim runs
               if (cnt_ff == CNT_W'(TRIM_CYC - 1)) begin
                  nxt_state = ADCST_IDLE;
                  nxt_cnt   = '0;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
            default: begin
               nxt_state = ADCST_IDLE;
               nxt_cnt   = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
   end

   assign trim_in_progress = (state_ff == ADCST_RUN);

   // Routing and span/offset selection, registered
   always_comb begin
      nxt_intlv    = ext_mode ? cfg_ff[CFG_INTLV_BIT] : intlv_s;
      nxt_alt      = ext_mode & cfg_ff[CFG_INTLV_BIT] & cfg_ff[CFG_ALT_BIT];
      nxt_i_span   = ext_mode ? i_rng_ff : (span_s ? RANGE_PIN_HI : RANGE_PIN_LO);
      nxt_q_span   = ext_mode ? q_rng_ff : (span_s ? RANGE_PIN_HI : RANGE_PIN_LO);
      nxt_i_offo   = ext_mode ? i_off_ff : OFFSET_RST;
      nxt_q_offo   = ext_mode ? q_off_ff : OFFSET_RST;
      nxt_ext_mode = ext_mode;
      // One pin sets coupling for both inputs, so one bias enable serves both
      nxt_bias     = ~coup_s;
      if (rst) begin
         nxt_intlv    = 1'b0;
         nxt_alt      = 1'b0;
         nxt_i_span   = RANGE_PIN_LO;
         nxt_q_span   = RANGE_PIN_LO;
         nxt_i_offo   = OFFSET_RST;
         nxt_q_offo   = OFFSET_RST;
         nxt_ext_mode = 1'b0;
         nxt_bias     = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      intlv_ff    <= nxt_intlv;
      alt_ff      <= nxt_alt;
      ext_mode_ff <= nxt_ext_mode;
      bias_ff     <= nxt_bias;
      i_span_ff   <= nxt_i_span;
      q_span_ff   <= nxt_q_span;
      i_offo_ff   <= nxt_i_offo;
      q_offo_ff   <= nxt_q_offo;
   end

   assign extended_pin_override_mode = ext_mode_ff;
   assign interleave_en       = intlv_ff;
   // Independent: I takes primary, Q its own; interleaved: both take one input
   assign ch_i_uses_secondary = intlv_ff & alt_ff;
   assign ch_q_uses_secondary = ~intlv_ff | alt_ff;
   assign ch_q_active         = 1'b1;
   assign i_span              = i_span_ff;
   assign q_span              = q_span_ff;
   assign i_offset            = i_offo_ff;
   assign q_offset            = q_offo_ff;
   assign input_bias_en       = bias_ff;

   property p_run_len;
      @(posedge mclk) disable iff (rst) $rose(trim_in_progress) |-> trim_in_progress [*8];
   endproperty
   a_run_len: assert property (p_run_len) else $error("trim ended too soon");

   property p_run_from_arm;
      @(posedge mclk) disable iff (rst) $rose(trim_in_progress) |-> $past(state_ff) == ADCST_ARM && $past(eff_req);
   endproperty
   a_run_from_arm: assert property (p_run_from_arm) else $error("trim started without request");

   property p_ignore;
      @(posedge mclk) disable iff (rst) trim_in_progress && cnt_ff != CNT_W'(TRIM_CYC - 1) |=> trim_in_progress;
   endproperty
   a_ignore: assert property (p_ignore) else $error("trim cut short");

   // A set request bit must keep the low-interval count cleared even with the pin low
   property p_eff;
      @(posedge mclk) disable iff (rst)
         ext_mode && cfg_ff[CFG_TRIM_BIT] && state_ff == ADCST_IDLE |=> state_ff == ADCST_IDLE && cnt_ff == '0;
   endproperty
   a_eff: assert property (p_eff) else $error("request bit does not hold off the low count");

   property p_defaults;
      @(posedge mclk) disable iff (rst) !ext_mode |=> cfg_ff == CFG_RST && i_rng_ff == RANGE_RST;
   endproperty
   a_defaults: assert property (p_defaults) else $error("registers not at default");

   property p_span_pin;
      @(posedge mclk) disable iff (rst) !ext_mode |=> i_span == q_span;
   endproperty
   a_span_pin: assert property (p_span_pin) else $error("spans differ in pin mode");

   property p_span_reg;
      @(posedge mclk) disable iff (rst) ext_mode |=> q_span == $past(q_rng_ff);
   endproperty
   a_span_reg: assert property (p_span_reg) else $error("Q span not from register");

   property p_intlv;
      @(posedge mclk) disable iff (rst) !ext_mode |=> interleave_en == $past(intlv_s) && !ch_i_uses_secondary;
   endproperty
   a_intlv: assert property (p_intlv) else $error("interleave routing wrong");

   property p_run_end;
      @(posedge mclk) disable iff (rst) trim_in_progress && cnt_ff == CNT_W'(TRIM_CYC - 1) |=> !trim_in_progress;
   endproperty
   a_run_end: assert property (p_run_end) else $error("trim ran too long");

   property p_rearm;
      @(posedge mclk) disable iff (rst) $fell(trim_in_progress) |-> state_ff == ADCST_IDLE && cnt_ff == '0;
   endproperty
   a_rearm: assert property (p_rearm) else $error("trim end kept an old low interval");

   property p_offset_pin;
      @(posedge mclk) disable iff (rst) !ext_mode |=> i_offset == OFFSET_RST && q_offset == OFFSET_RST;
   endproperty
   a_offset_pin: assert property (p_offset_pin) else $error("offset applied in pin mode");

   property p_route_indep;
      @(posedge mclk) disable iff (rst) !interleave_en |-> !ch_i_uses_secondary && ch_q_uses_secondary && ch_q_active;
   endproperty
   a_route_indep: assert property (p_route_indep) else $error("independent routing wrong");

   property p_route_intlv;
      @(posedge mclk) disable iff (rst) interleave_en |-> ch_i_uses_secondary == ch_q_uses_secondary;
   endproperty
   a_route_intlv: assert property (p_route_intlv) else $error("channels take different inputs");

   property p_bias;
      @(posedge mclk) disable iff (rst) coup_s |=> !input_bias_en;
   endproperty
   a_bias: assert property (p_bias) else $error("bias left on in direct coupling");

   c_trim: cover property (@(posedge mclk) disable iff (rst) $rose(trim_in_progress));
   c_ext_trim: cover property (@(posedge mclk) disable iff (rst) ext_mode && !req_pin_s ##1 $rose(trim_in_progress));
   c_alt: cover property (@(posedge mclk) disable iff (rst) ch_i_uses_secondary);
   c_reject: cover property (@(posedge mclk) disable iff (rst) trim_in_progress && !req_pin_s);
   c_direct: cover property (@(posedge mclk) disable iff (rst) !input_bias_en && !interleave_en);
endmodule
`default_nettype wire

// File: tb/adcst_host_model.sv
// Host side model: drives the trim request pin.
// Assumes go and hold_low come from the bench on rising mclk edges.
`timescale 1ns/1ps
`default_nettype none
module adcst_host_model
   import adcst_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic go,
   input  wire logic hold_low,
   output logic      trim_req_pin
);
   int cnt;

   always @(posedge mclk) begin
      if (rst) begin
         trim_req_pin <= 1'b1;
         cnt          <= 0;
      end else if (go) begin
         // Low with margin over the sync delay, then high unless hold_low keeps it low
         trim_req_pin <= 1'b0;
         cnt          <= TRIG_LOW_CYC + 4;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1 && !hold_low) begin
         trim_req_pin <= 1'b1;
         cnt          <= 0;
      end
   end
endmodule
`default_nettype wire

// File: tb/adcst_top_test.sv
// Bench for adcst_top: pin mode, trim requests and extended control.
// Assumes the host model drives the request pin; all else comes from here.
`timescale 1ns/1ps
`default_nettype none
module adcst_top_test;
   import adcst_pkg::*;
   logic mclk, rst, trim_req_pin, ext_n, ilv_pin, span_pin, cpl_pin, go, hold_low;
   logic        reg_wr;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, i_span, q_span, i_offset, q_offset;
   logic        trim, ext_mode, ilv, i_sec, q_sec, q_act, bias;
   int          failures, compares, cycles;

   adcst_host_model host (.mclk(mclk), .rst(rst), .go(go), .hold_low(hold_low), .trim_req_pin(trim_req_pin));
   adcst_top dut (.mclk(mclk), .rst(rst), .trim_req_pin(trim_req_pin), .ext_ctrl_enable_n(ext_n),
      .interleave_pin(ilv_pin), .input_span_select(span_pin), .coupling_select(cpl_pin), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .trim_in_progress(trim),
      .extended_pin_override_mode(ext_mode), .interleave_en(ilv), .ch_i_uses_secondary(i_sec),
      .ch_q_uses_secondary(q_sec), .ch_q_active(q_act), .i_span(i_span), .q_span(q_span),
      .i_offset(i_offset), .q_offset(q_offset), .input_bias_en(bias));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic wrap_up();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Run is about 400 cycles; a hang is cut well beyond that
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      @(negedge mclk);
      chk(reg_rdata, exp);
   endtask

   task automatic pulse();
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
   endtask

   // Flags packed as ext mode, interleave, i secondary, q secondary, q active, bias
   task automatic flags(input logic [5:0] exp);
      @(negedge mclk);
      chk({10'h000, ext_mode, ilv, i_sec, q_sec, q_act, bias}, {10'h000, exp});
   endtask

   // Bounded wait for the trim, then its length in cycles
   task automatic trim_chk();
      int w;
      int n;
      w = 0;
      n = 0;
      while (trim !== 1'b1 && w < 100) begin
         @(negedge mclk);
         w++;
      end
      while (trim === 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      chk(16'(n), 16'(TRIM_CYC));
   endtask

   initial begin
      int n;
      rst = 1'b1; ext_n = 1'b1; ilv_pin = 1'b1; span_pin = 1'b0; cpl_pin = 1'b0;
      go = 1'b0; hold_low = 1'b0; reg_wr = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
      cycles = 0; failures = 0; compares = 0;
      cyc(10);
      rst <= 1'b0;
      cyc(6);
      flags(6'b010011);
      chk(i_span, RANGE_PIN_LO);
      chk(q_span, RANGE_PIN_LO);
      @(posedge mclk);
      ilv_pin <= 1'b0; span_pin <= 1'b1; cpl_pin <= 1'b1;
      cyc(6);
      flags(6'b000110);
      chk(i_span, RANGE_PIN_HI);
      chk(q_span, RANGE_PIN_HI);
      wr(REG_I_RANGE, 16'h1234);
      rd(REG_I_RANGE, RANGE_RST);
      $display("test pin_mode done");

      pulse();
      fork
         trim_chk();
         begin
            wait (trim === 1'b1);
            pulse();
         end
      join
      n = 0;
      repeat (40) @(negedge mclk) if (trim !== 1'b0) n++;
      chk(16'(n), 16'h0000);
      $display("test trim_pin done");

      @(posedge mclk);
      ext_n <= 1'b0;
      cyc(4);
      wr(REG_I_RANGE, 16'h1111);
      wr(REG_Q_RANGE, 16'h2222);
      wr(REG_I_OFFSET, 16'h0333);
      wr(REG_Q_OFFSET, 16'h0444);
      span_pin <= 1'b0;
      cyc(6);
      chk(i_span, 16'h1111);
      chk(q_span, 16'h2222);
      chk(i_offset, 16'h0333);
      chk(q_offset, 16'h0444);
      rd(REG_Q_RANGE, 16'h2222);
      rd(REG_Q_OFFSET, 16'h0444);
      rd(4'h5, 16'h0000);
      wr(REG_CFG, 16'h00C0);
      cyc(3);
      flags(6'b111110);
      wr(REG_CFG, 16'h0080);
      cyc(3);
      flags(6'b110010);
      rd(REG_CFG, 16'h0080);
      pulse();
      trim_chk();
      $display("test ext_regs done");

      @(posedge mclk);
      hold_low <= 1'b1;
      pulse();
      cyc(TRIG_LOW_CYC + 8);
      wr(REG_CFG, 16'h8080);
      fork
         trim_chk();
         begin
            wait (trim === 1'b1);
            rd(REG_CFG, 16'h8081);
         end
      join
      @(posedge mclk);
      ext_n <= 1'b1;
      cyc(6);
      rd(REG_I_OFFSET, OFFSET_RST);
      chk(i_span, RANGE_PIN_LO);
      chk(i_offset, 16'h0000);
      $display("test ext_trim done");
      wrap_up();
   end
endmodule
`default_nettype wire
